// ==== ptc_port_t.sv ====
// Port T pin control: registers on AHB-Lite, direction overrides, pulls and timer routing
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] Input-level reads return buffered pin state of all eight pins, any direction.
// [R2] Writes to the input-level register are ignored.
// [R3] Direction bit 1 makes the pin output, 0 input, unless overridden.
// [R4] Enabled LCD segment disables both pin buffers, over direction and timer.
// [R5] Upper pins forced output when first-timer compare channel enabled, no LCD.
// [R6] Lower pins forced output when second-timer compare channel enabled, no LCD.
// [R7] Reads may lag direction changes by up to two clocks via synchronisers.
// [R8] Pull enable turns pull device on; no effect while pin is output.
// [R9] Polarity bit 1 selects pull-down, 0 pull-up, only when pull enabled.
// [R10] Routing bits 7:6 place first-timer ch7 on T7, R1, V6; 11 gives T7.
// [R11] Routing bit 5 places first-timer ch5 on T5 or V2.
// [R12] Routing bit 4 places first-timer ch4 on T4 or V0.
// [R13] Routing bits 3:2 place first-timer ch6 on T6, R0, V4; 11 gives T6.
// [R14] Routing bit 1 places second-timer ch7 on T3 or R3.
// [R15] Routing bit 0 places second-timer ch6 on T2 or R2.
// [R16] Control registers read and write at any time.
// [R17] Reserved location reads zero and discards writes.
// [R18] Data reads give register bit for outputs, pin state for inputs.
// [R19] All control bits reset to zero: inputs, no pulls, default routing.
module ptc_port_t (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  tport_pin_in,
  output logic      [7:0]  tport_pin_out,
  output logic      [7:0]  tport_pin_oe,
  output logic      [7:0]  tport_pin_ie,
  output logic      [7:0]  tport_pull_up_en,
  output logic      [7:0]  tport_pull_down_en,
  input  wire logic [7:0]  lcd_segment_en,
  input  wire logic [7:0]  lcd_segment_out,
  input  wire logic [3:0]  first_timer_oc_en,
  input  wire logic [3:0]  first_timer_oc_out,
  input  wire logic [3:0]  second_timer_oc_en,
  input  wire logic [3:0]  second_timer_oc_out,
  output logic      [7:0]  first_timer_ic_in,
  output logic      [3:0]  second_timer_ic_in,
  output logic             rport_pin0,
  output logic             rport_pin1,
  output logic             rport_pin2,
  output logic             rport_pin3,
  output logic             vport_pin0,
  output logic             vport_pin2,
  output logic             vport_pin4,
  output logic             vport_pin6,
  output logic      [7:0]  alt_route_en
);
  import ptc_pkg::*;

  logic [7:0] port_t_output_data_q;
  logic [7:0] port_t_direction_q;
  logic [7:0] port_t_pull_enable_q;
  logic [7:0] port_t_pull_polarity_q;
  logic [7:0] port_t_channel_routing_q;
  logic [7:0] pin_sync1_q;
  logic [7:0] pin_sync2_q;
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_data_d;
  logic [7:0] oc_en;
  logic [7:0] oc_out;
  logic [7:0] oc_on_t;
  logic [7:0] oe_d;
  logic [7:0] ie_d;
  logic [7:0] out_d;
  logic [1:0] sel_ch7;
  logic [1:0] sel_ch6;
  logic       sel_ch5;
  logic       sel_ch4;
  logic       sel_t2ch7;
  logic       sel_t2ch6;
  logic       addr_phase;

  assign addr_phase = hsel & htrans[1] & hready;

  // Timer channels in pin order: pins 7..4 first timer, 3..0 second timer
  assign oc_en  = {first_timer_oc_en, second_timer_oc_en};
  assign oc_out = {first_timer_oc_out, second_timer_oc_out};

  // [R10] ch7 select, 11 folds to T
  assign sel_ch7 = (port_t_channel_routing_q[PTC_ROUTE_CH7_LSB +: 2] == 2'h3) ?
                   PTC_SEL_TPORT : port_t_channel_routing_q[PTC_ROUTE_CH7_LSB +: 2];
  // [R13] ch6 select, 11 folds to T
  assign sel_ch6 = (port_t_channel_routing_q[PTC_ROUTE_CH6_LSB +: 2] == 2'h3) ?
                   PTC_SEL_TPORT : port_t_channel_routing_q[PTC_ROUTE_CH6_LSB +: 2];
  // [R11] ch5 select
  assign sel_ch5   = port_t_channel_routing_q[PTC_ROUTE_CH5_BIT];
  // [R12] ch4 select
  assign sel_ch4   = port_t_channel_routing_q[PTC_ROUTE_CH4_BIT];
  // [R14] second ch7 select
  assign sel_t2ch7 = port_t_channel_routing_q[PTC_ROUTE_T2CH7_BIT];
  // [R15] second ch6 select
  assign sel_t2ch6 = port_t_channel_routing_q[PTC_ROUTE_T2CH6_BIT];

  // A channel drives its port T pin only while routed there
  always_comb begin
    oc_on_t    = oc_en;
    oc_on_t[7] = oc_en[7] & (sel_ch7 == PTC_SEL_TPORT);
    oc_on_t[6] = oc_en[6] & (sel_ch6 == PTC_SEL_TPORT);
    oc_on_t[5] = oc_en[5] & ~sel_ch5;
    oc_on_t[4] = oc_en[4] & ~sel_ch4;
    oc_on_t[3] = oc_en[3] & ~sel_t2ch7;
    oc_on_t[2] = oc_en[2] & ~sel_t2ch6;
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      always_comb begin
        if (lcd_segment_en[i]) begin
          // [R4] LCD kills buffers
          oe_d[i]  = 1'b0;
          ie_d[i]  = 1'b0;
          out_d[i] = lcd_segment_out[i];
        end else if (oc_on_t[i]) begin
          // [R5] [R6] timer forces output
          oe_d[i]  = 1'b1;
          ie_d[i]  = 1'b1;
          out_d[i] = oc_out[i];
        end else begin
          // [R3] direction bit rules
          oe_d[i]  = port_t_direction_q[i];
          ie_d[i]  = 1'b1;
          out_d[i] = port_t_output_data_q[i];
        end
      end
    end
  endgenerate

  // [R3] pin drive enable, registered so the pad sees no glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tport_pin_oe <= PTC_RESET_BYTE;
    end else begin
      tport_pin_oe <= oe_d;
    end
  end

  // [R4] input buffer enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tport_pin_ie <= PTC_RESET_BYTE;
    end else begin
      tport_pin_ie <= ie_d;
    end
  end

  // Pin output value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tport_pin_out <= PTC_RESET_BYTE;
    end else begin
      tport_pin_out <= out_d;
    end
  end

  // Pulls follow the same next driver state, so LCD pins never get a pull
  // [R8] [R9] pull-up when enabled, idle and polarity 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tport_pull_up_en <= PTC_RESET_BYTE;
    end else begin
      tport_pull_up_en <= port_t_pull_enable_q & ~oe_d & ie_d & ~port_t_pull_polarity_q;
    end
  end

  // [R8] [R9] pull-down when enabled, idle and polarity 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tport_pull_down_en <= PTC_RESET_BYTE;
    end else begin
      tport_pull_down_en <= port_t_pull_enable_q & ~oe_d & ie_d & port_t_pull_polarity_q;
    end
  end

  // [R7] two-stage pin synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync1_q <= PTC_RESET_BYTE;
      pin_sync2_q <= PTC_RESET_BYTE;
    end else begin
      pin_sync1_q <= tport_pin_in;
      pin_sync2_q <= pin_sync1_q;
    end
  end

  // Capture inputs are registered from the synchronised pin, so they lag the pad by three clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_timer_ic_in  <= PTC_RESET_BYTE;
      second_timer_ic_in <= 4'h0;
    end else begin
      first_timer_ic_in  <= {pin_sync2_q[7:4], 4'h0};
      second_timer_ic_in <= pin_sync2_q[3:0];
    end
  end

  // Rerouted pins always mirror the compare output; alt_route_en says when it counts
  // [R10] [R13] [R14] [R15] port R pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rport_pin0 <= 1'b0;
      rport_pin1 <= 1'b0;
      rport_pin2 <= 1'b0;
      rport_pin3 <= 1'b0;
    end else begin
      rport_pin0 <= first_timer_oc_out[2];
      rport_pin1 <= first_timer_oc_out[3];
      rport_pin2 <= second_timer_oc_out[2];
      rport_pin3 <= second_timer_oc_out[3];
    end
  end

  // [R10] [R11] [R12] [R13] port V pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vport_pin0 <= 1'b0;
      vport_pin2 <= 1'b0;
      vport_pin4 <= 1'b0;
      vport_pin6 <= 1'b0;
    end else begin
      vport_pin0 <= first_timer_oc_out[0];
      vport_pin2 <= first_timer_oc_out[1];
      vport_pin4 <= first_timer_oc_out[2];
      vport_pin6 <= first_timer_oc_out[3];
    end
  end

  // Route status, one bit per alternative pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alt_route_en <= PTC_RESET_BYTE;
    end else begin
      // [R10] ch7 to R1/V6
      alt_route_en[0] <= first_timer_oc_en[3] & (sel_ch7 == PTC_SEL_RPORT);
      alt_route_en[1] <= first_timer_oc_en[3] & (sel_ch7 == PTC_SEL_VPORT);
      // [R13] ch6 to R0/V4
      alt_route_en[2] <= first_timer_oc_en[2] & (sel_ch6 == PTC_SEL_RPORT);
      alt_route_en[3] <= first_timer_oc_en[2] & (sel_ch6 == PTC_SEL_VPORT);
      // [R11] ch5 to V2
      alt_route_en[4] <= first_timer_oc_en[1] & sel_ch5;
      // [R12] ch4 to V0
      alt_route_en[5] <= first_timer_oc_en[0] & sel_ch4;
      // [R14] second ch7 to R3
      alt_route_en[6] <= second_timer_oc_en[3] & sel_t2ch7;
      // [R15] second ch6 to R2
      alt_route_en[7] <= second_timer_oc_en[2] & sel_t2ch6;
    end
  end

  // AHB-Lite address phase capture; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // [R16] [R19] control registers, written in the data phase at any time
  // [R2] [R17] no write block decodes the input-level or reserved offsets
  // Data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_t_output_data_q <= PTC_RESET_BYTE;
    end else if (wr_pend_q && wr_addr_q == PTC_OFS_OUTPUT_DATA) begin
      port_t_output_data_q <= hwdata[7:0];
    end
  end

  // Direction register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_t_direction_q <= PTC_RESET_BYTE;
    end else if (wr_pend_q && wr_addr_q == PTC_OFS_DIRECTION) begin
      port_t_direction_q <= hwdata[7:0];
    end
  end

  // Pull enable register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_t_pull_enable_q <= PTC_RESET_BYTE;
    end else if (wr_pend_q && wr_addr_q == PTC_OFS_PULL_ENABLE) begin
      port_t_pull_enable_q <= hwdata[7:0];
    end
  end

  // Pull polarity register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_t_pull_polarity_q <= PTC_RESET_BYTE;
    end else if (wr_pend_q && wr_addr_q == PTC_OFS_PULL_POL) begin
      port_t_pull_polarity_q <= hwdata[7:0];
    end
  end

  // Routing register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_t_channel_routing_q <= PTC_RESET_BYTE;
    end else if (wr_pend_q && wr_addr_q == PTC_OFS_ROUTING) begin
      port_t_channel_routing_q <= hwdata[7:0];
    end
  end

  // Read mux, evaluated on the address phase so data is ready in the data phase
  always_comb begin
    unique case (haddr[7:0])
      // [R18] data read source
      PTC_OFS_OUTPUT_DATA: rd_data_d = (port_t_direction_q & port_t_output_data_q) |
                                       (~port_t_direction_q & pin_sync2_q);
      // [R1] buffered pin state
      PTC_OFS_INPUT_LEVEL: rd_data_d = pin_sync2_q;
      PTC_OFS_DIRECTION:   rd_data_d = port_t_direction_q;
      // [R17] reads zero
      PTC_OFS_RESERVED:    rd_data_d = PTC_RESERVED_VALUE;
      PTC_OFS_PULL_ENABLE: rd_data_d = port_t_pull_enable_q;
      PTC_OFS_PULL_POL:    rd_data_d = port_t_pull_polarity_q;
      PTC_OFS_ROUTING:     rd_data_d = port_t_channel_routing_q;
      PTC_OFS_ALT_ENABLE:  rd_data_d = alt_route_en;
      default:             rd_data_d = 8'h00;
    endcase
  end

  // Read data is loaded in the address phase and stands until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= {24'h00_0000, rd_data_d};
    end
  end

  // No wait states and no error response: every location is always reachable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== ptc_pkg.sv ====
// Package for the port T pin control block: register map and reset values
package ptc_pkg;
  localparam logic [7:0] PTC_OFS_OUTPUT_DATA  = 8'h00;
  localparam logic [7:0] PTC_OFS_INPUT_LEVEL  = 8'h04;
  localparam logic [7:0] PTC_OFS_DIRECTION    = 8'h08;
  localparam logic [7:0] PTC_OFS_RESERVED     = 8'h0c;
  localparam logic [7:0] PTC_OFS_PULL_ENABLE  = 8'h10;
  localparam logic [7:0] PTC_OFS_PULL_POL     = 8'h14;
  localparam logic [7:0] PTC_OFS_ROUTING      = 8'h18;
  localparam logic [7:0] PTC_OFS_ALT_ENABLE   = 8'h1c;
  localparam logic [7:0] PTC_RESET_BYTE       = 8'h00;
  localparam logic [7:0] PTC_RESERVED_VALUE   = 8'h00;
  localparam int         PTC_ROUTE_CH7_LSB    = 6;
  localparam int         PTC_ROUTE_CH5_BIT    = 5;
  localparam int         PTC_ROUTE_CH4_BIT    = 4;
  localparam int         PTC_ROUTE_CH6_LSB    = 2;
  localparam int         PTC_ROUTE_T2CH7_BIT  = 1;
  localparam int         PTC_ROUTE_T2CH6_BIT  = 0;
  localparam logic [1:0] PTC_SEL_TPORT        = 2'h0;
  localparam logic [1:0] PTC_SEL_RPORT        = 2'h1;
  localparam logic [1:0] PTC_SEL_VPORT        = 2'h2;
endpackage

// ==== ptc_pin_model.sv ====
// Pin-side model of the eight port T pads with pulls and an optional short
`timescale 1ns/1ps
`default_nettype none
module ptc_pin_model (
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] pd,
  input  wire logic [7:0] ext,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin
);
  // A short beats the driver; an undriven pin without pull reads the inverse of its output value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ext_en[i])
        pin[i] = ext[i];
      else if (oe[i])
        pin[i] = out[i];
      else if (pd[i])
        pin[i] = 1'b0;
      else if (pu[i])
        pin[i] = 1'b1;
      else
        pin[i] = ~out[i];
    end
  end
endmodule
`default_nettype wire

// ==== ptc_port_t_props.sv ====
// Concurrent checks on the port T pin control ports
`timescale 1ns/1ps
`default_nettype none
module ptc_port_t_props
  import ptc_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  tport_pin_in,
  input wire logic [7:0]  tport_pin_oe,
  input wire logic [7:0]  tport_pin_ie,
  input wire logic [7:0]  tport_pull_up_en,
  input wire logic [7:0]  tport_pull_down_en,
  input wire logic [7:0]  lcd_segment_en,
  input wire logic [3:0]  first_timer_oc_en,
  input wire logic [3:0]  first_timer_oc_out,
  input wire logic [3:0]  second_timer_oc_en,
  input wire logic        rport_pin1,
  input wire logic [7:0]  alt_route_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  lcd_no_buffer_a: assert property (
    ((tport_pin_oe | tport_pin_ie) & $past(lcd_segment_en)) == 8'h00) else $error("lcd pin buffered");
  ie_follows_lcd_a: assert property (
    $past(hresetn) |-> tport_pin_ie == ~$past(lcd_segment_en)) else $error("input buffer wrong");
  timer_upper_a: assert property (
    $past(first_timer_oc_en[1] && !lcd_segment_en[5]) && !alt_route_en[4] |-> tport_pin_oe[5])
    else $error("upper timer pin not output");
  timer_lower_a: assert property (
    $past(second_timer_oc_en[2] && !lcd_segment_en[2]) && !alt_route_en[7] |-> tport_pin_oe[2])
    else $error("lower timer pin not output");
  pull_off_out_a: assert property (
    ((tport_pull_up_en | tport_pull_down_en) & tport_pin_oe) == 8'h00) else $error("pull on output");
  pull_one_way_a: assert property (
    (tport_pull_up_en & tport_pull_down_en) == 8'h00) else $error("both pulls on");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or error");
  reserved_zero_a: assert property (
    hsel && htrans[1] && !hwrite && haddr[7:0] == PTC_OFS_RESERVED |=> hrdata == 32'h0)
    else $error("reserved read not zero");
  level_read_a: assert property (
    hsel && htrans[1] && !hwrite && haddr[7:0] == PTC_OFS_INPUT_LEVEL && $stable(tport_pin_in)
    && $past(tport_pin_in, 2) == tport_pin_in |=> hrdata == {24'h0, $past(tport_pin_in)})
    else $error("input level read wrong");
  route_mirror_a: assert property (
    $past(hresetn) |-> rport_pin1 == $past(first_timer_oc_out[3])) else $error("rport pin1 wrong");
endmodule
bind ptc_port_t ptc_port_t_props i_ptc_port_t_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hrdata, .hreadyout, .hresp, .tport_pin_in, .tport_pin_oe, .tport_pin_ie,
  .tport_pull_up_en, .tport_pull_down_en, .lcd_segment_en, .first_timer_oc_en,
  .first_timer_oc_out, .second_timer_oc_en, .rport_pin1, .alt_route_en);
`default_nettype wire

// ==== tb_port_t_pin_control.sv ====
// Testbench for the port T pin control block
`timescale 1ns/1ps
`default_nettype none
module tb_port_t_pin_control;
  import ptc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, r0, r1, r2, r3, v0, v2, v4, v6;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [7:0]  pin, ext, ext_en, out, oe, ie, pu, pd, lcd, alt, ic1;
  logic [3:0]  t1_en, t1_out, t2_en, t2_out, ic2;
  logic [23:0] rt [11] = '{24'h0000ff, 24'h40017f, 24'h80027f, 24'hc000ff, 24'h2010df,
    24'h1020ef, 24'h0404bf, 24'h0808bf, 24'h0c00ff, 24'h0240f7, 24'h0180fb};
  int          fail_count, checks;
  ptc_port_t i_ptc_port_t (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tport_pin_in(pin),
    .tport_pin_out(out), .tport_pin_oe(oe), .tport_pin_ie(ie), .tport_pull_up_en(pu),
    .tport_pull_down_en(pd), .lcd_segment_en(lcd), .lcd_segment_out(8'h5a),
    .first_timer_oc_en(t1_en), .first_timer_oc_out(t1_out), .second_timer_oc_en(t2_en),
    .second_timer_oc_out(t2_out), .first_timer_ic_in(ic1), .second_timer_ic_in(ic2),
    .rport_pin0(r0), .rport_pin1(r1), .rport_pin2(r2), .rport_pin3(r3), .vport_pin0(v0),
    .vport_pin2(v2), .vport_pin4(v4), .vport_pin6(v6), .alt_route_en(alt));
  ptc_pin_model i_ptc_pin_model (.oe(oe), .out(out), .pu(pu), .pd(pd), .ext(ext),
    .ext_en(ext_en), .pin(pin));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic end_of_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One single word transfer; hreadyout is waited for at both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  initial begin
    #200us;
    fail_count++;
    end_of_test();
  end
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, haddr, htrans, hwdata, ext, ext_en, lcd, t1_en, t2_en} = '0;
    t1_out = 4'h6;
    t2_out = 4'h9;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 8; a < 28; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      chk("reset reg", 32'h0, q);
    end
    settle(1);
    chk("reset oe ie", 32'h00ff, {oe, ie});
    chk("reset pulls", 32'h0, {pu, pd});
    bus(1'b1, PTC_OFS_PULL_ENABLE, 32'hff);
    bus(1'b1, PTC_OFS_PULL_POL, 32'h0f);
    bus(1'b1, PTC_OFS_DIRECTION, 32'h3c);
    bus(1'b1, PTC_OFS_OUTPUT_DATA, 32'ha5);
    ext_en <= 8'h04;
    settle(3);
    chk("pulls", 32'hc003, {pu, pd});
    chk("oe", 32'h3c, oe);
    bus(1'b0, PTC_OFS_OUTPUT_DATA, 32'h0);
    chk("data", 32'he4, q);
    bus(1'b1, PTC_OFS_INPUT_LEVEL, 32'h55);
    bus(1'b0, PTC_OFS_INPUT_LEVEL, 32'h0);
    chk("input level", 32'he0, q);
    chk("capture", 32'he00, {ic1, ic2});
    bus(1'b1, PTC_OFS_RESERVED, 32'hff);
    bus(1'b0, PTC_OFS_RESERVED, 32'h0);
    chk("reserved", 32'h0, q);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    lcd <= 8'h24;
    settle(2);
    chk("lcd buffers", 32'h18db, {oe, ie});
    chk("lcd out", 32'h81, out);
    @(posedge hclk);
    t1_en <= 4'hf;
    t2_en <= 4'hf;
    settle(2);
    chk("lcd over timer", 32'hdbdb, {oe, ie});
    @(posedge hclk);
    lcd <= 8'h00;
    bus(1'b1, PTC_OFS_DIRECTION, 32'h0);
    settle(2);
    chk("timer out", 32'h69, out);
    for (int i = 0; i < 11; i++) begin
      bus(1'b1, PTC_OFS_ROUTING, {24'h0, rt[i][23:16]});
      bus(1'b0, PTC_OFS_ROUTING, 32'h0);
      chk("routing", {8'h0, rt[i]}, {8'h0, q[7:0], alt, oe});
    end
    chk("alt pins", 32'h96, {r3, r2, r1, r0, v6, v4, v2, v0});
    end_of_test();
  end
endmodule
`default_nettype wire
